// [cwl_config_loader.sv]
// start-up loader of per-port configuration fields with an apb view
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cwl_regs.svh"
module cwl_config_loader
  import cwl_pkg::*;
#(
  parameter logic [15:0] STORE_SIGNATURE = 16'h5a3c  // arbitrary value
)(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             eeCs,
  output logic             eeSck,
  output logic             eeDo,
  input  wire logic        eeDi,
  output cwl_imgs_t        portCfg,
  output logic             loadDone
);
  // ************************************************************
  // field mapping of one start-up word
  // ************************************************************
  function automatic cwl_imgs_t applyWord(
    input cwl_imgs_t   im,
    input logic [7:0]  a,
    input logic [15:0] w
  );
    cwl_imgs_t r;
    r = im;
    // same values into every port in one step, except word 0x20 which goes to port 0 only
    for (int p = 0; p < 4; p++) begin
      unique case (a)
        `CWL_W_0C: begin
          r[p][`CWL_IX_8C][1] = w[13];
          r[p][`CWL_IX_E4][12] = w[14];
          r[p][`CWL_IX_8C][3] = w[15];
        end
        `CWL_W_0E: begin
          r[p][`CWL_IX_94][14:0] = w[14:0];
          r[p][`CWL_IX_E4][18] = w[15];
        end
        `CWL_W_10: begin
          r[p][`CWL_IX_74][30:16] = w[14:0];
          r[p][`CWL_IX_8C][31] = w[15];
        end
        `CWL_W_12: begin
          r[p][`CWL_IX_78][30:16] = w[14:0];
          r[p][`CWL_IX_8C][16] = w[15];
        end
        `CWL_W_14: begin
          r[p][`CWL_IX_7C][6:0] = w[6:0];
          r[p][`CWL_IX_90][19:15] = w[11:7];
          r[p][`CWL_IX_8C][20:17] = w[15:12];
        end
        `CWL_W_16: r[p][`CWL_IX_84][15:0] = w;
        `CWL_W_18: r[p][`CWL_IX_84][31:16] = w;
        `CWL_W_1A: r[p][`CWL_IX_88][15:0] = w;
        `CWL_W_1C: begin
          r[p][`CWL_IX_88][23:16] = w[7:0];
          r[p][`CWL_IX_8C][23:21] = w[10:8];
          r[p][`CWL_IX_98][20:16] = w[15:11];
        end
        `CWL_W_1E: begin
          r[p][`CWL_IX_90][31:20] = w[11:0];
          r[p][`CWL_IX_8C][29:26] = w[15:12];
        end
        `CWL_W_20: begin
          // lane controls of the upstream port only
          if (p == 0) begin
            r[p][`CWL_IX_78][7:0] = w[7:0];
            r[p][`CWL_IX_68][14:13] = w[9:8];
            r[p][`CWL_IX_78][9:8] = w[11:10];
            r[p][`CWL_IX_78][10] = w[12];
            r[p][`CWL_IX_78][13:12] = w[14:13];
            r[p][`CWL_IX_78][14] = w[15];
          end
        end
        default: ;
      endcase
    end
    return r;
  endfunction : applyWord

  // ************************************************************
  // default words and the image they produce
  // ************************************************************
  function automatic logic [15:0] defaultWord(input logic [7:0] a);
    unique case (a)
      `CWL_W_0C: return `CWL_D_0C;
      `CWL_W_0E: return `CWL_D_0E;
      `CWL_W_10: return `CWL_D_10;
      `CWL_W_12: return `CWL_D_12;
      `CWL_W_14: return `CWL_D_14;
      `CWL_W_16: return `CWL_D_16;
      `CWL_W_18: return `CWL_D_18;
      `CWL_W_1A: return `CWL_D_1A;
      `CWL_W_1C: return `CWL_D_1C;
      `CWL_W_1E: return `CWL_D_1E;
      `CWL_W_20: return `CWL_D_20;
      default:   return 16'h0000;
    endcase
  endfunction : defaultWord

  function automatic cwl_imgs_t defaultImgs();
    cwl_imgs_t im;
    logic [7:0] a;
    im = '0;
    a = `CWL_W_0C;
    while (a <= `CWL_W_20) begin
      im = applyWord(im, a, defaultWord(a));
      a = a + `CWL_W_STEP;
    end
    return im;
  endfunction : defaultImgs

  localparam cwl_imgs_t DEF_IMGS = defaultImgs();

  // ************************************************************
  // offset decode of the per-port window
  // ************************************************************
  function automatic logic [3:0] regIndex(input logic [7:0] off);
    unique case (off)
      `CWL_OFF_68: return `CWL_IX_68;
      `CWL_OFF_74: return `CWL_IX_74;
      `CWL_OFF_78: return `CWL_IX_78;
      `CWL_OFF_7C: return `CWL_IX_7C;
      `CWL_OFF_84: return `CWL_IX_84;
      `CWL_OFF_88: return `CWL_IX_88;
      `CWL_OFF_8C: return `CWL_IX_8C;
      `CWL_OFF_90: return `CWL_IX_90;
      `CWL_OFF_94: return `CWL_IX_94;
      `CWL_OFF_98: return `CWL_IX_98;
      `CWL_OFF_E4: return `CWL_IX_E4;
      default:     return `CWL_IX_NONE;
    endcase
  endfunction : regIndex

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cwl_ld_phase_t phase;
    logic [7:0]    wordAddr;
    logic          present;
    logic [3:0]    wordsLoaded;
    cwl_imgs_t     imgs;
    logic [31:0]   rdata;
    logic          err;
  } cwl_ld_state_t;

  cwl_ld_state_t s, next_s;
  cwl_rd_if rd ();

  logic        setup;
  logic        access;
  logic [3:0]  page;
  logic [7:0]  offset;
  logic [3:0]  rdIdx;
  logic [3:0][31:0] portRd;
  logic        busy;
  logic [31:0] statusWord;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign page = paddr[11:8];
  assign offset = paddr[7:0];
  assign rdIdx = regIndex(offset);
  assign busy = (s.phase != LD_DONE);
  // busy, done, store found, words taken, next word address
  assign statusWord = {16'h0000, s.wordAddr, s.wordsLoaded, 1'b0, s.present, ~busy, busy};

  // ************************************************************
  // per-port read select
  // ************************************************************
  generate
    for (genvar p = 0; p < 4; p++) begin : g_port
      // index 11 to 14 never occur; decode gives 15 for holes, and that reads as zero here
      assign portRd[p] = (rdIdx == `CWL_IX_NONE) ? 32'h0000_0000 : s.imgs[p][rdIdx];
    end
  endgenerate

  // ************************************************************
  // loader sequence and apb slave
  // ************************************************************
  always_comb begin
    next_s = s;
    // signature first, then mapped words in ascending order
    unique case (s.phase)
      LD_ISSUE: next_s.phase = LD_WAIT;
      LD_WAIT: begin
        if (rd.valid) begin
          if (s.wordAddr == `CWL_W_SIG) begin
            // blank or missing store reads all ones: keep defaults
            if (rd.data == STORE_SIGNATURE) begin
              next_s.present = 1'b1;
              next_s.wordAddr = `CWL_W_0C;
              next_s.phase = LD_ISSUE;
            end else begin
              next_s.phase = LD_DONE;
            end
          end else begin
            next_s.imgs = applyWord(s.imgs, s.wordAddr, rd.data);
            next_s.wordsLoaded = s.wordsLoaded + 4'd1;
            if (s.wordAddr == `CWL_W_20) begin
              next_s.phase = LD_DONE;
            end else begin
              next_s.wordAddr = s.wordAddr + `CWL_W_STEP;
              next_s.phase = LD_ISSUE;
            end
          end
        end
      end
      LD_DONE: ;
    endcase
    // read data and error are settled in the setup cycle
    if (setup) begin
      next_s.rdata = 32'h0000_0000;
      next_s.err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
        next_s.err = 1'b1;
      end else if (page == 4'h0) begin
        if (offset == `CWL_A_STATUS && !pwrite) next_s.rdata = statusWord;
        else if (offset != `CWL_A_CTRL) next_s.err = 1'b1;
      end else if (page <= 4'h4 && rdIdx != `CWL_IX_NONE && !pwrite) begin
        next_s.rdata = portRd[2'(page - 4'h1)];
      end else begin
        // images are loaded, not written: writes and holes fail
        next_s.err = 1'b1;
      end
    end
    // reload restarts from defaults; ignored while a pass runs
    if (access && pwrite && !s.err && page == 4'h0 && offset == `CWL_A_CTRL) begin
      if (pwdata[`CWL_CTRL_RELOAD] && !busy) begin
        next_s.imgs = DEF_IMGS;
        next_s.wordAddr = `CWL_W_SIG;
        next_s.present = 1'b0;
        next_s.wordsLoaded = 4'h0;
        next_s.phase = LD_ISSUE;
      end
    end
  end

  // pass starts right after reset with defaults already in place
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{phase: LD_ISSUE, wordAddr: `CWL_W_SIG, imgs: DEF_IMGS, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // serial store reader
  // ************************************************************
  assign rd.req = (s.phase == LD_ISSUE);
  assign rd.wordIdx = {1'b0, s.wordAddr[7:1]};

  cwl_word_reader u_reader (
    .clock  (clock),
    .arst_n (arst_n),
    .rd     (rd),
    .eeCs   (eeCs),
    .eeSck  (eeSck),
    .eeDo   (eeDo),
    .eeDi   (eeDi)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  // zero wait states: every access completes in its first access cycle
  assign pready = access;
  assign prdata = s.rdata;
  assign pslverr = access & s.err;
  assign portCfg = s.imgs;
  assign loadDone = ~busy;
endmodule : cwl_config_loader
`default_nettype wire

// [cwl_regs.svh]
// register offsets, field positions, start-up words and timing for the config loader
`ifndef CWL_REGS_SVH
`define CWL_REGS_SVH
// ************************************************************
// store word addresses (byte address of each 16-bit word)
// ************************************************************
`define CWL_W_SIG   8'h00
`define CWL_W_0C    8'h0c
`define CWL_W_0E    8'h0e
`define CWL_W_10    8'h10
`define CWL_W_12    8'h12
`define CWL_W_14    8'h14
`define CWL_W_16    8'h16
`define CWL_W_18    8'h18
`define CWL_W_1A    8'h1a
`define CWL_W_1C    8'h1c
`define CWL_W_1E    8'h1e
`define CWL_W_20    8'h20
`define CWL_W_STEP  8'h02
// ************************************************************
// default values of the start-up words
// ************************************************************
`define CWL_D_0C    16'h4211
`define CWL_D_0E    16'h916b
`define CWL_D_10    16'h0a73
`define CWL_D_12    16'hf6b5
`define CWL_D_14    16'hc0a7
`define CWL_D_16    16'h0000
`define CWL_D_18    16'h0000
`define CWL_D_1A    16'h3333
`define CWL_D_1C    16'h7b08
`define CWL_D_1E    16'h0000
`define CWL_D_20    16'h0080
// ************************************************************
// per-port configuration offsets and their image index
// ************************************************************
`define CWL_OFF_68  8'h68
`define CWL_OFF_74  8'h74
`define CWL_OFF_78  8'h78
`define CWL_OFF_7C  8'h7c
`define CWL_OFF_84  8'h84
`define CWL_OFF_88  8'h88
`define CWL_OFF_8C  8'h8c
`define CWL_OFF_90  8'h90
`define CWL_OFF_94  8'h94
`define CWL_OFF_98  8'h98
`define CWL_OFF_E4  8'he4
`define CWL_IX_68   4'h0
`define CWL_IX_74   4'h1
`define CWL_IX_78   4'h2
`define CWL_IX_7C   4'h3
`define CWL_IX_84   4'h4
`define CWL_IX_88   4'h5
`define CWL_IX_8C   4'h6
`define CWL_IX_90   4'h7
`define CWL_IX_94   4'h8
`define CWL_IX_98   4'h9
`define CWL_IX_E4   4'ha
`define CWL_IX_NONE 4'hf
// ************************************************************
// apb map of the loader's own registers
// ************************************************************
`define CWL_A_CTRL    8'h00
`define CWL_A_STATUS  8'h04
`define CWL_CTRL_RELOAD 0
// ************************************************************
// serial clock timing
// ************************************************************
`define CWL_CLK_PS      8000
`define CWL_SCK_HALF_NS 250
`define CWL_SCK_HALF_CYC ((`CWL_SCK_HALF_NS * 1000 + `CWL_CLK_PS - 1) / `CWL_CLK_PS)
`define CWL_RD_LAST_OUT 5'd10
`define CWL_RD_LAST_BIT 5'd26
`endif

// [cwl_pkg.sv]
// types shared by the config loader and its serial word reader
package cwl_pkg;
  typedef logic [31:0] cwl_word_t;
  typedef cwl_word_t [10:0] cwl_port_img_t;
  typedef cwl_port_img_t [3:0] cwl_imgs_t;
  typedef enum logic [2:0] {
    LD_ISSUE = 3'b001,
    LD_WAIT  = 3'b010,
    LD_DONE  = 3'b100
  } cwl_ld_phase_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RUN  = 2'b10
  } cwl_rd_phase_t;
endpackage : cwl_pkg

// [cwl_rd_if.sv]
// word read request and answer between loader and serial reader
`timescale 1ns/1ps
`default_nettype none
interface cwl_rd_if;
  logic        req;
  logic [7:0]  wordIdx;
  logic        valid;
  logic [15:0] data;
  logic        busy;
  modport loader (output req, output wordIdx, input valid, input data, input busy);
  modport reader (input req, input wordIdx, output valid, output data, output busy);
endinterface : cwl_rd_if
`default_nettype wire

// [cwl_word_reader.sv]
// three-wire serial store reader: one 16-bit word per request
`timescale 1ns/1ps
`default_nettype none
`include "cwl_regs.svh"
module cwl_word_reader
  import cwl_pkg::*;
(
  input  wire logic clock,
  input  wire logic arst_n,
  cwl_rd_if.reader  rd,
  output logic      eeCs,
  output logic      eeSck,
  output logic      eeDo,
  input  wire logic eeDi
);
  typedef struct packed {
    cwl_rd_phase_t phase;
    logic [5:0]    div;
    logic [4:0]    bitNo;
    logic          sck;
    logic          cs;
    logic [10:0]   shift;
    logic [15:0]   din;
    logic          valid;
  } cwl_rd_state_t;
  cwl_rd_state_t s, next_s;
  localparam logic [5:0] HALF_LAST = 6'(`CWL_SCK_HALF_CYC - 1);
  // start bit, read opcode, word index; data sampled late in the high phase
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    unique case (s.phase)
      RD_IDLE: begin
        if (rd.req) begin
          next_s.phase = RD_RUN;
          next_s.shift = {3'b110, rd.wordIdx};
          next_s.bitNo = 5'd0;
          next_s.div = 6'd0;
          next_s.cs = 1'b1;
        end
      end
      RD_RUN: begin
        if (s.div != HALF_LAST) begin
          next_s.div = s.div + 6'd1;
        end else begin
          next_s.div = 6'd0;
          next_s.sck = ~s.sck;
          if (s.sck) begin
            next_s.shift = {s.shift[9:0], 1'b0};
            // first cycle after the address already carries the data msb; there is no dummy bit
            if (s.bitNo > `CWL_RD_LAST_OUT) next_s.din = {s.din[14:0], eeDi};
            if (s.bitNo == `CWL_RD_LAST_BIT) begin
              next_s.phase = RD_IDLE;
              next_s.cs = 1'b0;
              next_s.valid = 1'b1;
            end else begin
              next_s.bitNo = s.bitNo + 5'd1;
            end
          end
        end
      end
    endcase
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) s <= '{phase: RD_IDLE, default: '0};
    else s <= next_s;
  end
  assign eeCs = s.cs;
  assign eeSck = s.sck;
  assign eeDo = s.shift[10];
  assign rd.valid = s.valid;
  assign rd.data = s.din;
  assign rd.busy = (s.phase == RD_RUN);
endmodule : cwl_word_reader
`default_nettype wire

// [cwl_store_model.sv]
// behavioural serial store answering one 16-bit word per frame
`timescale 1ns/1ps
`default_nettype none
module cwl_store_model (
  input  wire logic eeCs,
  input  wire logic eeSck,
  input  wire logic eeDo,
  output var logic  eeDi,
  output int        readCount,
  output int        orderErr
);
  // ********************
  // word array and frame state
  // ********************
  logic [15:0] mem [0:255];
  logic [10:0] cmd;
  logic [15:0] sh;
  logic [7:0]  prevIdx;
  int          nBits;

  // blank store until the bench programs it
  initial begin
    eeDi = 1'b0;
    readCount = 0;
    orderErr = 0;
    nBits = 0;
    prevIdx = 8'h00;
    cmd = 11'h000;
    sh = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hffff;
  end

  // a new frame restarts the bit count
  always @(posedge eeCs) begin
    nBits = 0;
  end

  // start, opcode and address shift in on rising sck
  always @(posedge eeSck) begin
    if (eeCs) begin
      if (nBits < 11) cmd = {cmd[9:0], eeDo};
      nBits++;
      if (nBits == 11) begin
        // a frame restarting at word 0 opens a new pass
        if (cmd[10:8] !== 3'b110 || (cmd[7:0] != 8'h00 && cmd[7:0] <= prevIdx)) orderErr++;
        prevIdx = cmd[7:0];
        readCount++;
        sh = mem[cmd[7:0]];
      end
    end
  end

  // data leaves msb first while sck is low
  always @(negedge eeSck) begin
    if (eeCs && nBits >= 11 && nBits <= 26) begin
      eeDi <= sh[15];
      sh = {sh[14:0], 1'b0};
    end
  end

  // released line: never leave the last bit standing
  always @(negedge eeCs) begin
    eeDi <= ~eeDi;
  end
endmodule : cwl_store_model
`default_nettype wire

// [cwl_config_loader_chk.sv]
// port-level assertions for the config word loader
`timescale 1ns/1ps
`default_nettype none
module cwl_config_loader_chk
  import cwl_pkg::*;
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        eeCs,
  input wire logic        eeSck,
  input wire logic        eeDo,
  input wire logic        eeDi,
  input wire cwl_imgs_t   portCfg,
  input wire logic        loadDone
);
  // ********************
  // bus and serial link timing
  // ********************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  chk_ready_access: assert property (pready == (psel && penable))
    else $error("pready not tied to the access phase");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside an access phase");
  // read data may only move on the edge that closes a setup cycle
  chk_rdata_hold: assert property (!($past(psel) && !$past(penable)) |-> $stable(prdata))
    else $error("read data moved during access");
  chk_cs_gap: assert property ($fell(eeCs) |=> !eeCs)
    else $error("store select gap too short");
  // serial clock stands still between frames
  chk_sck_still: assert property (!eeCs && !$past(eeCs) |-> !eeSck)
    else $error("serial clock runs outside a frame");
  chk_sck_half: assert property ($rose(eeSck) |-> ##32 $fell(eeSck))
    else $error("serial clock high phase not 32 cycles");
  chk_do_low: assert property ($changed(eeDo) |-> !eeSck)
    else $error("store data moved while clock high");
  chk_idle_quiet: assert property (loadDone |-> !eeCs)
    else $error("store selected while loader idle");
  chk_reload_start: assert property ($fell(loadDone) |-> ##[1:4] eeCs)
    else $error("reload did not open a frame");
  // ********************
  // image consistency
  // ********************
  chk_ports_same: assert property (portCfg[1] == portCfg[2] && portCfg[2] == portCfg[3])
    else $error("ports one to three differ");
  chk_cfg_quiet: assert property ($changed(portCfg) |-> !loadDone || !$past(loadDone))
    else $error("image changed while loader idle");
endmodule : cwl_config_loader_chk
`default_nettype wire

// [tb.sv]
// bench: blank store, programmed store, reload to defaults, refused accesses
`timescale 1ns/1ps
`default_nettype none
`include "cwl_regs.svh"
module tb
  import cwl_pkg::*;
;
  // ********************
  // stimulus and expectations
  // ********************
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, eeCs, eeSck, eeDo, eeDi, loadDone;
  cwl_imgs_t   portCfg;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          rdCount, ordErr;
  logic [15:0] dflt [0:10] = '{`CWL_D_0C, `CWL_D_0E, `CWL_D_10, `CWL_D_12, `CWL_D_14,
    `CWL_D_16, `CWL_D_18, `CWL_D_1A, `CWL_D_1C, `CWL_D_1E, `CWL_D_20};
  logic [15:0] prog [0:10] = '{16'ha000, 16'h8c21, 16'h9234, 16'h8765, 16'h5fa3,
    16'h1357, 16'h2468, 16'hbeef, 16'hd5c3, 16'hc9a6, 16'hdf5a};
  logic [7:0]  offs [0:10] = '{8'h68, 8'h74, 8'h78, 8'h7c, 8'h84, 8'h88, 8'h8c,
    8'h90, 8'h94, 8'h98, 8'he4};

  always #4 clock = ~clock;

  cwl_config_loader dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eeCs(eeCs), .eeSck(eeSck), .eeDo(eeDo), .eeDi(eeDi),
    .portCfg(portCfg), .loadDone(loadDone));
  cwl_store_model store (.eeCs(eeCs), .eeSck(eeSck), .eeDo(eeDo), .eeDi(eeDi),
    .readCount(rdCount), .orderErr(ordErr));

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // a hung load pass ends the run here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      summarize();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never reassigns psel in this time step
    @(posedge clock);
  endtask : apb

  function automatic logic [31:0] expv(input logic [15:0] w [0:10], input int p, input int ix);
    logic [31:0] v;
    v = 32'h0;
    case (ix)
      0: if (p == 0) v[14:13] = w[10][9:8];
      1: v[30:16] = w[2][14:0];
      2: begin
        v[30:16] = w[3][14:0];
        if (p == 0) v[14:0] = {w[10][15:13], 1'b0, w[10][12:10], w[10][7:0]};
      end
      3: v[6:0] = w[4][6:0];
      4: v = {w[6], w[5]};
      5: v[23:0] = {w[8][7:0], w[7]};
      6: v = {w[2][15], 1'b0, w[9][15:12], 2'b0, w[8][10:8], w[4][15:12], w[3][15],
              12'h0, w[0][15], 1'b0, w[0][13], 1'b0};
      7: v = {w[9][11:0], w[4][11:7], 15'h0};
      8: v[14:0] = w[1][14:0];
      9: v[20:16] = w[8][15:11];
      10: v = {13'h0, w[1][15], 5'h0, w[0][14], 12'h0};
      default: v = 32'h0;
    endcase
    return v;
  endfunction : expv

  // every image word of every port, direct and over apb
  task automatic check_images(input logic [15:0] w [0:10]);
    logic [31:0] rd;
    logic        er;
    for (int p = 0; p < 4; p++) begin
      for (int ix = 0; ix < 11; ix++) begin
        check(portCfg[p][ix], expv(w, p, ix), "image");
        apb(1'b0, 12'((p + 1) * 256) + 12'(offs[ix]), 32'h0, rd, er);
        check(rd, expv(w, p, ix), "apb image");
        check({31'h0, er}, 32'h0, "apb image error");
      end
    end
  endtask : check_images

  // let the falling done flag land, then wait for the pass to end
  task wait_done;
    repeat (4) @(posedge clock);
    while (loadDone !== 1'b1) @(posedge clock);
  endtask : wait_done

  task automatic load_pass(input logic [15:0] w [0:10], input logic [2:0] st, input int n);
    logic [31:0] rd;
    logic        er;
    wait_done();
    check_images(w);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    check({29'h0, rd[2:0]}, {29'h0, st}, "status");
    check(32'(rdCount), 32'(n), "words read");
    check(32'(ordErr), 32'h0, "read order");
  endtask : load_pass

  task automatic restart;
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 12'h000, 32'h1, rd, er);
  endtask : restart

  // refused places answer with an error and leave images alone
  task automatic test_refuse;
    logic [31:0] rd;
    logic        er;
    logic [11:0] bad [0:3] = '{12'h008, 12'h102, 12'h1f0, 12'h600};
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0, rd, er);
      check({31'h0, er}, 32'h1, "refused read");
    end
    apb(1'b1, 12'h004, 32'hffff_ffff, rd, er);
    check({31'h0, er}, 32'h1, "status write");
    apb(1'b1, 12'h18c, 32'hffff_ffff, rd, er);
    check({31'h0, er}, 32'h1, "image write");
    check(portCfg[0][6], expv(dflt, 0, 6), "image after write");
    apb(1'b0, 12'h000, 32'h0, rd, er);
    check(rd, 32'h0, "control read");
    $display("test refused accesses done");
  endtask : test_refuse

  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    load_pass(dflt, 3'b010, 1);
    $display("test blank store done");
    store.mem[0] = 16'h5a3c;
    foreach (prog[i]) store.mem[6 + i] = prog[i];
    restart();
    // second reload lands while the pass runs and must be ignored
    restart();
    load_pass(prog, 3'b110, 13);
    $display("test programmed store done");
    store.mem[0] = 16'hffff;
    restart();
    load_pass(dflt, 3'b010, 14);
    $display("test reload to defaults done");
    test_refuse();
    summarize();
  end
endmodule : tb

bind cwl_config_loader cwl_config_loader_chk chk (.clock(clock), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeCs(eeCs), .eeSck(eeSck),
  .eeDo(eeDo), .eeDi(eeDi), .portCfg(portCfg), .loadDone(loadDone));
`default_nettype wire
